// ---- design/bank_map.sv ----
// Maps a register number and mode to a physical register slot
`timescale 1ns/1ps
`default_nettype none
`include "regfile_regs.svh"
module bank_map
	import regfile_pkg::*;
(
	input wire reg_idx_t idx,
	input wire logic priv,
	input wire logic bank_sel,
	input wire logic other_bank,
	output logic [4:0] slot
);
	wire logic banked = ~idx[3];
	wire logic use_alt = priv & (bank_sel ^ other_bank);
	// Slots 0-7 primary set, 8-15 upper registers, 16-23 alternate set
	assign slot = (banked & use_alt) ? {2'b10, idx[2:0]} : {1'b0, idx};
endmodule : bank_map
`default_nettype wire

// ---- design/banked_cpu_register_file.sv ----
// Banked general register file with control register reset values
// How it works
// - Sixteen 32-bit general registers for data, addresses.
// - Reset clears vector base, DSP status; loads PC.
// - Reset sets mode, bank, mask bits; level 1111.
// - Register 0 is the index register.
// - Some instructions may use register 0 only.
// - Register 15 is the stack pointer.
// - Exceptions save status and PC via register 15.
// - X access: pointer registers 4,5; index 8.
// - Y access: pointer registers 6,7; index 9.
// - Single access: pointers 2 to 5; index 8.
// - Two independent X and Y pointer sets.
// - Registers 0-7 banked; user mode uses bank 0.
// - Privileged: bank-select bit picks bank 0 or 1.
// - Mode bit 1 privileged, 0 user.
// - Unused bank reachable only by control transfers.
//
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "regfile_regs.svh"
module banked_cpu_register_file
	import regfile_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire reg_idx_t rd_a_idx,
	input wire read_src_t rd_a_src,
	input wire logic rd_a_other_bank,
	output word_t rd_a_data,
	input wire reg_idx_t rd_b_idx,
	output word_t rd_b_data,
	input wire logic wr_en,
	input wire reg_idx_t wr_idx,
	input wire read_src_t wr_src,
	input wire logic wr_other_bank,
	input wire word_t wr_data,
	input wire logic sw_wr_en,
	input wire word_t sw_wr_data,
	input wire logic pc_wr_en,
	input wire word_t pc_wr_data,
	input wire logic vbr_wr_en,
	input wire word_t vbr_wr_data,
	input wire logic dsr_wr_en,
	input wire word_t dsr_wr_data,
	input wire logic [1:0] x_ptr_sel,
	input wire logic [1:0] y_ptr_sel,
	input wire logic [1:0] s_ptr_sel,
	output word_t x_addr_pointer,
	output word_t x_index_value,
	output word_t y_addr_pointer,
	output word_t y_index_value,
	output word_t single_addr_pointer,
	output word_t single_index_value,
	output word_t stack_pointer_reg,
	output word_t index_capable_reg,
	output word_t status_word,
	output word_t program_counter,
	output word_t vector_base,
	output word_t dsp_status,
	output logic privilege_mode_bit,
	output logic bank_select_bit,
	output logic exception_mask_bit,
	output logic [3:0] intr_level_mask
);
	// 24 physical slots: two sets of eight banked plus eight shared
	word_t regs_r [0:23];
	word_t sw_r;
	word_t pc_r;
	word_t vbr_r;
	word_t dsr_r;

	// Effective register number: index-only or stack-only ops force it
	function automatic reg_idx_t eff_idx(input reg_idx_t idx, input read_src_t src);
		unique case (src)
			SRC_INDEX: eff_idx = `REG_INDEX;
			SRC_STACK: eff_idx = `REG_STACK;
			default: eff_idx = idx;
		endcase
	endfunction : eff_idx

	// Slot of a register in the current bank, mode taken from the live word
	function automatic logic [4:0] cur_slot(input reg_idx_t idx);
		cur_slot = (~idx[3] & sw_r[`SW_MD_BIT] & sw_r[`SW_RB_BIT]) ?
			{2'b10, idx[2:0]} : {1'b0, idx};
	endfunction : cur_slot

	wire logic md = sw_r[`SW_MD_BIT];
	wire logic rb = sw_r[`SW_RB_BIT];
	wire reg_idx_t a_idx = eff_idx(rd_a_idx, rd_a_src);
	wire reg_idx_t w_idx = eff_idx(wr_idx, wr_src);
	wire logic [4:0] a_slot;
	wire logic [4:0] w_slot;

	// The opposite bank is only reached by the control-transfer path, in privileged mode
	bank_map u_map_a (
		.idx(a_idx),
		.priv(md),
		.bank_sel(rb),
		.other_bank(rd_a_other_bank),
		.slot(a_slot)
	);
	bank_map u_map_w (
		.idx(w_idx),
		.priv(md),
		.bank_sel(rb),
		.other_bank(wr_other_bank),
		.slot(w_slot)
	);

	// Pointer registers: X, Y and single sets are addressed independently
	wire reg_idx_t x_ptr_idx = `REG_X_PTR0 | {3'b000, x_ptr_sel[0]};
	wire reg_idx_t y_ptr_idx = `REG_Y_PTR0 | {3'b000, y_ptr_sel[0]};
	wire reg_idx_t s_ptr_idx = `REG_S_PTR0 + {2'b00, s_ptr_sel};

	// Reads are combinational from the current state, so a status write
	// in one cycle steers the bank choice of every access after it
	assign rd_a_data = regs_r[a_slot];
	assign rd_b_data = regs_r[cur_slot(rd_b_idx)];
	assign x_addr_pointer = regs_r[cur_slot(x_ptr_idx)];
	assign x_index_value = regs_r[cur_slot(`REG_X_INDEX)];
	assign y_addr_pointer = regs_r[cur_slot(y_ptr_idx)];
	assign y_index_value = regs_r[cur_slot(`REG_Y_INDEX)];
	assign single_addr_pointer = regs_r[cur_slot(s_ptr_idx)];
	assign single_index_value = regs_r[cur_slot(`REG_S_INDEX)];
	assign stack_pointer_reg = regs_r[cur_slot(`REG_STACK)];
	assign index_capable_reg = regs_r[cur_slot(`REG_INDEX)];

	assign status_word = sw_r;
	assign program_counter = pc_r;
	assign vector_base = vbr_r;
	assign dsp_status = dsr_r;
	assign privilege_mode_bit = md;
	assign bank_select_bit = rb;
	assign exception_mask_bit = sw_r[`SW_BL_BIT];
	assign intr_level_mask = sw_r[`SW_IMASK_HI:`SW_IMASK_LO];

	// General registers have no reset value, so they are left out of the reset
	always_ff @(posedge clk) begin
		if (wr_en) begin
			regs_r[w_slot] <= wr_data;
		end
	end

	// Undefined status bits are reset to zero here to keep simulation clean
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sw_r <= `SW_RESET;
			pc_r <= `RF_PC_RESET;
			vbr_r <= `RF_VBR_RESET;
			dsr_r <= `RF_DSR_RESET;
		end else begin
			if (sw_wr_en) begin
				sw_r <= sw_wr_data;
			end
			if (pc_wr_en) begin
				pc_r <= pc_wr_data;
			end
			if (vbr_wr_en) begin
				vbr_r <= vbr_wr_data;
			end
			if (dsr_wr_en) begin
				dsr_r <= dsr_wr_data;
			end
		end
	end
endmodule : banked_cpu_register_file
`default_nettype wire

// ---- design/regfile_pkg.sv ----
// Types shared by the banked register file
package regfile_pkg;
	typedef logic [31:0] word_t;
	typedef logic [3:0] reg_idx_t;
	typedef enum logic [1:0] {
		SRC_GENERAL = 2'h0,
		SRC_INDEX = 2'h1,
		SRC_STACK = 2'h3
	} read_src_t;
endpackage : regfile_pkg

// ---- design/regfile_regs.svh ----
// Constants for the banked CPU register file
`ifndef REGFILE_REGS_SVH
`define REGFILE_REGS_SVH
`define RF_VBR_RESET 32'h0000_0000
`define RF_DSR_RESET 32'h0000_0000
`define RF_PC_RESET 32'h0A00_0000
`define SW_MD_BIT 30
`define SW_RB_BIT 29
`define SW_BL_BIT 28
`define SW_IMASK_LO 4
`define SW_IMASK_HI 7
`define SW_IMASK_RESET 4'hF
`define SW_RESET 32'h7000_00F0
`define SW_DEFINED_MASK 32'h7000_00F0
`define REG_INDEX 4'h0
`define REG_STACK 4'hF
`define REG_X_INDEX 4'h8
`define REG_Y_INDEX 4'h9
`define REG_S_INDEX 4'h8
`define REG_X_PTR0 4'h4
`define REG_Y_PTR0 4'h6
`define REG_S_PTR0 4'h2
`endif

// ---- tb/banked_cpu_register_file_tb.sv ----
// Bench for the banked register file
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin fails++; \
	$display("CHECK FAILED %0t %h %h", $time, a, e); end end
module banked_cpu_register_file_tb
	import regfile_pkg::*;
;
	typedef struct packed {word_t s; reg_idx_t i; word_t d;} row_t;
	logic clk, rst_b, rd_a_other_bank, sw_wr_en, wr_en, cwe, wob, pm, bs, em;
	logic [3:0] ilm;
	logic [1:0] x_ptr_sel, y_ptr_sel, s_ptr_sel;
	reg_idx_t rd_a_idx, rd_b_idx, wr_idx;
	read_src_t rd_a_src;
	word_t sw_wr_data, wr_data, cw, rd_a_data, rd_b_data, x_addr_pointer, x_index_value;
	word_t y_addr_pointer, y_index_value, single_addr_pointer, single_index_value;
	word_t stack_pointer_reg, index_capable_reg, status_word, program_counter;
	word_t vector_base, dsp_status;
	int fails, check_count, cycles;
	// R0 and R4 get different values per bank so a wrong bank shows
	row_t rows [8] = '{'{32'h7000_0000, 4'h0, 32'h1}, '{32'h4000_0000, 4'h0, 32'h2},
		'{32'h2000_0000, 4'h4, 32'h3}, '{32'h6000_0000, 4'h4, 32'h4},
		'{32'h0, 4'h8, 32'h5}, '{32'h0, 4'h9, 32'h6},
		'{32'h0, 4'hF, 32'hFFFF_FFF7}, '{32'h7000_0000, 4'h6, 32'h8}};
	pipe_model m (.*);
	banked_cpu_register_file dut (.*, .wr_src(SRC_GENERAL), .wr_other_bank(wob),
		.pc_wr_en(cwe), .pc_wr_data(cw), .vbr_wr_en(cwe), .vbr_wr_data(cw),
		.dsr_wr_en(cwe), .dsr_wr_data(cw), .privilege_mode_bit(pm), .bank_select_bit(bs),
		.exception_mask_bit(em), .intr_level_mask(ilm));
	task automatic stop_test;
		if (fails == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : stop_test
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Work takes under 60 cycles; the ceiling leaves a wide margin
	always @(posedge clk) begin
		cycles++;
		if (cycles == 300) begin
			fails++;
			stop_test();
		end
	end
	initial begin
		{rst_b, rd_a_other_bank, cwe, wob, rd_a_idx, rd_b_idx, cw} = '0;
		{x_ptr_sel, y_ptr_sel, s_ptr_sel} = 6'h2;
		rd_a_src = SRC_GENERAL;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		foreach (rows[k]) begin
			m.put_mode(rows[k].s);
			m.put_reg(rows[k].i, rows[k].d);
			rd_b_idx <= rows[k].i;
			@(negedge clk);
			`CHK(rd_b_data, rows[k].d)
			@(posedge clk);
		end
		rd_b_idx <= 4'h0;
		rd_a_other_bank <= 1'b1;
		@(negedge clk);
		`CHK(rd_b_data, 32'h1)
		`CHK(rd_a_data, 32'h2)
		`CHK(index_capable_reg, 32'h1)
		`CHK(x_addr_pointer, 32'h4)
		`CHK(single_addr_pointer, 32'h4)
		`CHK(single_index_value, 32'h5)
		`CHK(y_addr_pointer, 32'h8)
		`CHK(y_index_value, 32'h6)
		`CHK(stack_pointer_reg, 32'hFFFF_FFF7)
		@(posedge clk);
		// Write R1 of the hidden bank 0 while bank 1 is live
		wob <= 1'b1;
		m.put_reg(4'h1, 32'hA);
		wob <= 1'b0;
		// User mode with the bank bit still set must fall back to bank 0
		m.put_mode(32'h2000_0000);
		rd_a_src <= SRC_STACK;
		@(negedge clk);
		`CHK({pm, bs}, 2'h1)
		`CHK(rd_b_data, 32'h2)
		`CHK(x_addr_pointer, 32'h3)
		`CHK(rd_a_data, 32'hFFFF_FFF7)
		@(posedge clk);
		rd_a_src <= SRC_INDEX;
		rd_b_idx <= 4'h1;
		cw <= 32'h1234_5678;
		cwe <= 1'b1;
		@(negedge clk);
		`CHK(rd_a_data, 32'h2)
		`CHK(rd_b_data, 32'hA)
		@(posedge clk);
		cwe <= 1'b0;
		@(posedge clk);
		rst_b <= 1'b0;
		@(negedge clk);
		`CHK(program_counter, 32'h0A00_0000)
		`CHK(vector_base | dsp_status, 32'h0)
		`CHK(status_word & 32'h7000_00F0, 32'h7000_00F0)
		`CHK({pm, bs, em, ilm}, 7'h7F)
		stop_test();
	end
endmodule : banked_cpu_register_file_tb
`default_nettype wire

// ---- tb/pipe_model.sv ----
// Pipeline side that issues mode and register writes
`timescale 1ns/1ps
`default_nettype none
module pipe_model
	import regfile_pkg::*;
(
	input wire logic clk,
	output logic sw_wr_en,
	output word_t sw_wr_data,
	output logic wr_en,
	output reg_idx_t wr_idx,
	output word_t wr_data
);
	initial {sw_wr_en, sw_wr_data, wr_en, wr_idx, wr_data} = '0;
	task automatic put_mode(input word_t s);
		sw_wr_en <= 1'b1;
		sw_wr_data <= s;
		@(posedge clk);
		sw_wr_en <= 1'b0;
	endtask : put_mode
	task automatic put_reg(input reg_idx_t i, input word_t d);
		wr_en <= 1'b1;
		wr_idx <= i;
		wr_data <= d;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask : put_reg
endmodule : pipe_model
`default_nettype wire

// ---- tb/regfile_checker.sv ----
// Port assertions for the banked register file
`timescale 1ns/1ps
`default_nettype none
module regfile_checker
	import regfile_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic sw_wr_en,
	input wire word_t sw_wr_data,
	input wire logic pc_wr_en,
	input wire word_t status_word,
	input wire word_t program_counter,
	input wire word_t vector_base,
	input wire word_t dsp_status
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	sequence reset_gone;
		$rose(rst_b);
	endsequence
	chk_reset_pc: assert property (reset_gone |-> program_counter == 32'h0A00_0000)
		else $error("pc not at reset value");
	chk_reset_base: assert property (reset_gone |-> vector_base == 32'h0 && dsp_status == 32'h0)
		else $error("base or dsp status not clear");
	chk_reset_sw: assert property (reset_gone |-> status_word[30:28] == 3'h7)
		else $error("status bits not set");
	chk_load_mode: assert property (sw_wr_en |=> status_word[30:29] == $past(sw_wr_data[30:29]))
		else $error("mode bits not loaded");
	chk_load_mask: assert property (sw_wr_en |=> status_word[28] == $past(sw_wr_data[28]))
		else $error("mask bit not loaded");
	chk_load_level: assert property (sw_wr_en |=> status_word[7:4] == $past(sw_wr_data[7:4]))
		else $error("level mask not loaded");
	chk_sw_hold: assert property (!sw_wr_en |=> $stable(status_word))
		else $error("status moved");
	chk_pc_hold: assert property (!pc_wr_en |=> $stable(program_counter))
		else $error("pc moved");
endmodule : regfile_checker
bind banked_cpu_register_file regfile_checker chk (.*);
`default_nettype wire
